// ### design/asr_pkg.sv
// Package of constants for the serial converter result read-out block.
package asr_pkg;
    localparam int          RESULT_BITS      = 12;
    localparam int          LEAD_ZEROS       = 2;
    localparam int          MSB_EDGE         = 3;
    localparam int          LSB_EDGE         = 14;
    localparam int          EDGE_CNT_W       = 5;
    localparam logic [4:0]  EDGE_CNT_RESET   = 5'h00;
    localparam logic [4:0]  EDGE_CNT_SAT     = 5'h1F;
    localparam logic [11:0] RESULT_RESET     = 12'h000;
    localparam int          SYNC_STAGES      = 3;
    localparam real         CLK_PERIOD_NS    = 10.0;
    localparam real         DOUT_DELAY_NS    = 20.0;
    localparam int          DOUT_DELAY_CYC   = (DOUT_DELAY_NS / CLK_PERIOD_NS) < 1.0 ? 1 :
                                               int'($floor(DOUT_DELAY_NS / CLK_PERIOD_NS));
endpackage : asr_pkg

// ### design/asr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter for one input bit.
`timescale 1ns/1ps
`default_nettype none
module asr_pin_sync
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    input  wire logic reset_level_in,
    output var  logic level_out
);
    logic s1;
    logic s2;
    logic s3;

    // Stage one is only read by stage two, so metastability stays contained.
    // Stages reset to the pin's idle level so no false edge follows reset.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s1 <= reset_level_in;
            s2 <= reset_level_in;
            s3 <= reset_level_in;
        end
        else
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts only once stages two and three agree.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            level_out <= reset_level_in;
        else if (s2 == s3)
            level_out <= s3;
    end
endmodule : asr_pin_sync
`default_nettype wire

// ### design/asr_readout.sv
// Device-side serial read-out of a 12-bit conversion result.
// Summary of operation
// - Data output is zero during the first two serial clocks.
// - Third rising edge gives the MSB, later edges the next bits.
// - After the LSB, further clocks with chip select low shift out zeros.
// - Two-byte read: three zeros plus five bits, then seven bits plus zero.
// - Chip select falling edge starts conversion and drives the output low.
// - Data output is high impedance whenever chip select is high.
// - Result is straight unsigned binary, zero at ground.
`timescale 1ns/1ps
`default_nettype none
module asr_readout
#(
    parameter int RESULT_BITS = asr_pkg::RESULT_BITS
)
(
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   cs_n_in,
    input  wire logic                   sclk_in,
    input  wire logic [RESULT_BITS-1:0] sample_in,
    output var  logic                   dout_out,
    output var  logic                   dout_oe_out,
    output var  logic                   busy_out,
    output var  logic                   done_out
);
    typedef enum logic [2:0]
    {
        ASR_IDLE  = 3'b001,
        ASR_SHIFT = 3'b010,
        ASR_TAIL  = 3'b100
    } asr_state_t;

    asr_state_t                         state;
    logic                               cs_n_s;
    logic                               sclk_s;
    logic                               cs_n_d;
    logic                               sclk_d;
    logic                               cs_fall;
    logic                               sclk_rise;
    logic [asr_pkg::EDGE_CNT_W-1:0]     edge_cnt;
    logic [RESULT_BITS-1:0]             result;

    // Chip select and serial clock come from the host and must be synchronised.
    asr_pin_sync u_cs_sync
    (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .pin_in         (cs_n_in),
        .reset_level_in (1'b1),
        .level_out      (cs_n_s)
    );

    asr_pin_sync u_sclk_sync
    (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .pin_in         (sclk_in),
        .reset_level_in (1'b0),
        .level_out      (sclk_s)
    );

    // Edge detection on the filtered levels; deselect is assumed at reset.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cs_n_d <= 1'b1;
            sclk_d <= 1'b0;
        end
        else
        begin
            cs_n_d <= cs_n_s;
            sclk_d <= sclk_s;
        end
    end

    assign cs_fall   = cs_n_d & ~cs_n_s;
    assign sclk_rise = ~sclk_d & sclk_s & ~cs_n_s;

    // Frame state: chip select high aborts any frame at once, which is how the host abort works.
    always_ff @(posedge clk_in)
    begin
        if (rst_in || cs_n_s)
            state <= ASR_IDLE;
        else
        begin
            unique case (state)
                ASR_IDLE:  if (cs_fall) state <= ASR_SHIFT;
                ASR_SHIFT: if (sclk_rise && edge_cnt == 5'(asr_pkg::LSB_EDGE)) state <= ASR_TAIL;
                ASR_TAIL:  state <= ASR_TAIL;
                default:   state <= ASR_IDLE;
            endcase
        end
    end

    // Rising edges counted in the frame; saturates so endless tails stay zero.
    always_ff @(posedge clk_in)
    begin
        if (rst_in || cs_n_s || cs_fall)
            edge_cnt <= asr_pkg::EDGE_CNT_RESET;
        else if (sclk_rise && edge_cnt != asr_pkg::EDGE_CNT_SAT)
            edge_cnt <= edge_cnt + 5'h01;
    end

    // The sample is held at the falling chip select, as unsigned binary.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            result <= asr_pkg::RESULT_RESET;
        else if (cs_fall)
            result <= sample_in;
        else if (sclk_rise && edge_cnt >= 5'(asr_pkg::MSB_EDGE - 1) && state == ASR_SHIFT)
            result <= {result[RESULT_BITS-2:0], 1'b0};
    end

    // Data changes one cycle after the sensed rising edge; zeros pad both ends.
    always_ff @(posedge clk_in)
    begin
        if (rst_in || cs_n_s)
            dout_out <= 1'b0;
        else if (cs_fall)
            dout_out <= 1'b0;
        else if (sclk_rise)
        begin
            if (edge_cnt < 5'(asr_pkg::LEAD_ZEROS))
                dout_out <= 1'b0;
            else if (state == ASR_SHIFT)
                dout_out <= result[RESULT_BITS-1];
            else
                dout_out <= 1'b0;
        end
    end

    // Output is driven only while chip select is low.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            dout_oe_out <= 1'b0;
        else
            dout_oe_out <= ~cs_n_s;
    end

    // Status flags decode the state register directly, so they add no latency.
    assign busy_out = (state == ASR_SHIFT);
    assign done_out = (state == ASR_TAIL);

    // Output released whenever the device is deselected.
    property p_hiz_when_deselected;
        @(posedge clk_in) disable iff (rst_in)
        cs_n_s |=> !dout_oe_out;
    endproperty
    a_hiz_when_deselected: assert property (p_hiz_when_deselected)
        else $error("Data output driven while deselected.");

    property p_low_on_start;
        @(posedge clk_in) disable iff (rst_in)
        cs_fall |=> !dout_out && busy_out;
    endproperty
    a_low_on_start: assert property (p_low_on_start)
        else $error("Frame start did not drive output low.");

    property p_lead_zeros;
        @(posedge clk_in) disable iff (rst_in)
        sclk_rise && edge_cnt < 5'h02 |=> !dout_out;
    endproperty
    a_lead_zeros: assert property (p_lead_zeros)
        else $error("Leading bit not zero.");

    property p_msb_first;
        @(posedge clk_in) disable iff (rst_in)
        sclk_rise && edge_cnt == 5'h02 && busy_out |=> dout_out == $past(result[RESULT_BITS-1]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("Third edge did not present the MSB.");

    property p_tail_zero;
        @(posedge clk_in) disable iff (rst_in)
        done_out && sclk_rise && !cs_n_s |=> !dout_out;
    endproperty
    a_tail_zero: assert property (p_tail_zero)
        else $error("Trailing bit not zero.");

    property p_tail_after_lsb;
        @(posedge clk_in) disable iff (rst_in)
        busy_out && sclk_rise && edge_cnt == 5'h0E && !cs_n_s |=> done_out;
    endproperty
    a_tail_after_lsb: assert property (p_tail_after_lsb)
        else $error("Frame did not end after the LSB.");

    property p_abort_idle;
        @(posedge clk_in) disable iff (rst_in)
        cs_n_s |=> !busy_out && !done_out;
    endproperty
    a_abort_idle: assert property (p_abort_idle)
        else $error("Deselect did not end the frame.");

    // The rise after the LSB must give the single trailing zero of the byte layout.
    property p_trailing_zero;
        @(posedge clk_in) disable iff (rst_in)
        busy_out && sclk_rise && edge_cnt == 5'h0E |=> !dout_out;
    endproperty
    a_trailing_zero: assert property (p_trailing_zero)
        else $error("Bit after the LSB not zero.");

    property p_sample_held;
        @(posedge clk_in) disable iff (rst_in)
        cs_fall |=> result == $past(sample_in);
    endproperty
    a_sample_held: assert property (p_sample_held)
        else $error("Sample not captured at start.");
endmodule : asr_readout
`default_nettype wire

// ### verification/asr_host_model.sv
// Host serial port model that masters chip select and the serial clock.
`timescale 1ns/1ps
`default_nettype none
module asr_host_model
(
    input  wire logic dout_in,
    input  wire logic dout_oe_in,
    output var  logic cs_n_out,
    output var  logic sclk_out
);
    // Idle with the device deselected and the clock parked low.
    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
    end

    // One frame of n clocks. Phase zero takes each bit just before a rising edge.
    // Phase one takes the bit left by each rise at the end of its period, since the
    // synchronised device answers too late for a capture on the falling edge.
    task automatic frame(input int n, input bit late, output logic [19:0] got);
        logic line;
        got = 20'h00000;
        cs_n_out = 1'b0;
        #80;
        for (int i = 0; i < n; i++)
        begin
            // A released line shows the inverse, so a floating read never passes.
            if (!late)
            begin
                line = dout_oe_in ? dout_in : ~dout_in;
                got = {got[18:0], line};
            end
            sclk_out = 1'b1;
            #40;
            sclk_out = 1'b0;
            #40;
            if (late)
            begin
                line = dout_oe_in ? dout_in : ~dout_in;
                got = {got[18:0], line};
            end
        end
        cs_n_out = 1'b1;
        #200;
    endtask : frame
endmodule : asr_host_model
`default_nettype wire

// ### verification/adc_serial_result_readout_tb_top.sv
// Self-checking bench for the serial result read-out block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
    begin \
        tests_run++; \
        if ((gt) !== (ex)) \
        begin \
            err_total++; \
            $display("wrong value %s expected %h seen %h", nm, ex, gt); \
        end \
    end
module adc_serial_result_readout_tb_top;
    logic        clk_in;
    logic        rst_in;
    logic        cs_n;
    logic        sclk;
    logic [11:0] sample;
    logic        dout;
    logic        dout_oe;
    logic        busy;
    logic        done;
    logic [19:0] got;
    logic [31:0] seed;
    int          err_total;
    int          tests_run;
    int          cyc;
    int          lens [6] = '{15, 16, 20, 6, 15, 17};
    bit          late [6] = '{0, 0, 0, 0, 1, 0};
    int          rise;
    int          exp_q [$];

    asr_readout i_dut (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk),
        .sample_in(sample), .dout_out(dout), .dout_oe_out(dout_oe), .busy_out(busy), .done_out(done));
    asr_host_model i_host (.dout_in(dout), .dout_oe_in(dout_oe), .cs_n_out(cs_n), .sclk_out(sclk));

    // Fixed-seed xorshift so every run sees the same values.
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic stop_test();
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // Clock, plus a hang guard well above the expected run length.
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            stop_test();
        end
    end

    initial
    begin
        rst_in = 1'b1;
        sample = 12'hFFF;
        seed = 32'h0000001A;
        repeat (4) @(posedge clk_in);
        #1 rst_in = 1'b0;
        repeat (6) @(posedge clk_in);
        #1;
        `CHK("oe idle", 1'b0, dout_oe)
        foreach (lens[f])
        begin
            exp_q.delete();
            // Each captured bit is the value left by rise number rise; zero outside rises 3 to 14.
            for (int i = 1; i <= lens[f]; i++)
            begin
                rise = late[f] ? i : i - 1;
                exp_q.push_back((rise <= 2 || rise > 14) ? 0 : (sample >> (14 - rise)) & 1);
            end
            fork
                i_host.frame(lens[f], late[f], got);
                begin
                    wait (cs_n === 1'b0);
                    repeat (7) @(posedge clk_in);
                    #1;
                    `CHK("oe frame", 1'b1, dout_oe)
                    `CHK("dout start", 1'b0, dout)
                    `CHK("busy start", 1'b1, busy)
                    wait (cs_n === 1'b1);
                    `CHK("done at deselect", lens[f] >= 15, done)
                    `CHK("busy at deselect", lens[f] < 15, busy)
                end
            join
            for (int i = 1; i <= lens[f]; i++)
                `CHK("bit", exp_q[i-1][0], got[lens[f]-i])
            `CHK("oe after", 1'b0, dout_oe)
            `CHK("idle after", 2'b00, {busy, done})
            seed = xs(seed);
            @(posedge clk_in);
            #1 sample = (f == 0) ? 12'h000 : seed[11:0];
        end
        stop_test();
    end
endmodule : adc_serial_result_readout_tb_top
`default_nettype wire
